// >>> cmbf_top.v
// Comparator blanking network and filter with AHB-Lite registers
// Contract
// R1 - Bit 15 of mask gating picks whether a low (set) or high (clear) comparator level is blanked.
// R2 - Bits 13, 11, 9 put mask inputs C, B, A straight into the OR gate.
// R3 - Bits 12, 10, 8 put inverted mask inputs C, B, A into the OR gate.
// R4 - Bit 7 puts the inverted AND output into the OR gate.
// R5 - Bit 6 puts the plain AND output into the OR gate.
// R6 - Bits 5, 3, 1 put mask inputs C, B, A straight into the AND gate.
// R7 - Bits 4, 2, 0 put inverted mask inputs C, B, A into the AND gate.
// R8 - Filter bits 6 to 4 pick the sample clock among timers, PWM sync, oscillator, peripheral; 011 reserved.
// R9 - Filter bit 3 inserts the digital filter; clear bypasses it.
// R10 - Filter bits 2 to 0 divide the sample clock by two to the power of the code.
// R11 - Filter control bits 15 to 7 read zero and ignore writes.
// R12 - Each mask input comes from a 4-bit selector of PWM, trigger and fault sources.
// R13 - While the OR output is high the chosen comparator level is held off downstream.
// R14 - The enabled filter passes a new level only after three equal divided samples.
`timescale 1ns/1ps
module cmbf_top (
    input wire hclk, // System clock, 20 MHz
    input wire hresetn, // Async reset, active low
    input wire hsel, // Slave select
    input wire [11:0] haddr, // Byte address
    input wire [1:0] htrans, // Transfer type
    input wire hwrite, // Write strobe
    input wire [2:0] hsize, // Transfer size
    input wire [31:0] hwdata, // Write data
    input wire hready, // Bus ready in
    output reg [31:0] hrdata, // Read data
    output reg hreadyout, // Always ready
    output reg hresp, // Always OKAY
    input wire cmp_in, // Raw comparator level
    input wire [5:0] pwm_out, // PWM outputs as mask sources
    input wire [1:0] trig_out, // Trigger generator outputs
    input wire [1:0] fault_in, // Fault inputs
    input wire timer5_clk, // Filter clock options
    input wire timer4_clk, // Timer 4 clock
    input wire timer3_clk, // Timer 3 clock
    input wire timer2_clk, // Timer 2 clock
    input wire pwm_sync_out, // PWM sync output
    input wire osc_clk, // Oscillator clock level
    input wire periph_clk, // Peripheral clock level
    output reg cmp_out, // Blanked, filtered comparator level
    output reg blank_active // OR gate output
);
`include "cmbf_defs.vh"
    reg [15:0] mask_gating_control;
    reg [15:0] filter_control;
    reg [15:0] mask_src_sel;
    reg wr_pend;
    reg [11:0] wr_addr;
    reg next_sclk;
    reg and_gate_out;
    reg or_out;
    reg blanked;
    wire [3:0] mask_a_src_sel;
    wire [3:0] mask_b_src_sel;
    wire [3:0] mask_c_src_sel;
    wire [2:0] filt_clk_src;
    wire [2:0] filt_clk_div;
    wire filt_en;
    wire blank_level_select;
    wire mask_in_a;
    wire mask_in_b;
    wire mask_in_c;
    wire filt_level;
    wire addr_ok;
    wire [15:0] m;
    assign m = mask_gating_control;
    assign blank_level_select = m[`CMBF_B_LVL];
    assign filt_clk_src = filter_control[`CMBF_FSRC_HI:`CMBF_FSRC_LO];
    assign filt_en = filter_control[`CMBF_B_FEN];
    assign filt_clk_div = filter_control[`CMBF_FDIV_HI:`CMBF_FDIV_LO];
    assign mask_a_src_sel = mask_src_sel[`CMBF_SA_HI:`CMBF_SA_LO];
    assign mask_b_src_sel = mask_src_sel[`CMBF_SB_HI:`CMBF_SB_LO];
    assign mask_c_src_sel = mask_src_sel[`CMBF_SC_HI:`CMBF_SC_LO];
    // Only nonsequential transfers are decoded; writes must also be whole-word
    assign addr_ok = hsel & hready & (htrans == `CMBF_HTRANS_NONSEQ);

    // =====================================
    // Mask source selectors
    cmbf_src_sel u_sel_a (
        .sel(mask_a_src_sel),
        .pwm(pwm_out),
        .trig(trig_out),
        .fault(fault_in),
        .out(mask_in_a)
    );
    cmbf_src_sel u_sel_b (
        .sel(mask_b_src_sel),
        .pwm(pwm_out),
        .trig(trig_out),
        .fault(fault_in),
        .out(mask_in_b)
    );
    cmbf_src_sel u_sel_c (
        .sel(mask_c_src_sel),
        .pwm(pwm_out),
        .trig(trig_out),
        .fault(fault_in),
        .out(mask_in_c)
    );

    // =====================================
    // Blanking logic network
    always @* begin
        // Empty AND gate reads low, so an unused gate blanks only through bit 7
        if (m[`CMBF_B_AND_C:`CMBF_B_AND_AN] == 6'h00) begin
            and_gate_out = 1'b0;
        end else begin
            and_gate_out = (~m[`CMBF_B_AND_C] | mask_in_c) & (~m[`CMBF_B_AND_CN] | ~mask_in_c) // R6 R7
                & (~m[`CMBF_B_AND_B] | mask_in_b) & (~m[`CMBF_B_AND_BN] | ~mask_in_b) // R6 R7
                & (~m[`CMBF_B_AND_A] | mask_in_a) & (~m[`CMBF_B_AND_AN] | ~mask_in_a); // R6 R7
        end
        or_out = (m[`CMBF_B_OR_C] & mask_in_c) | (m[`CMBF_B_OR_B] & mask_in_b) // R2
            | (m[`CMBF_B_OR_A] & mask_in_a) // R2
            | (m[`CMBF_B_OR_CN] & ~mask_in_c) | (m[`CMBF_B_OR_BN] & ~mask_in_b) // R3
            | (m[`CMBF_B_OR_AN] & ~mask_in_a) // R3
            | (m[`CMBF_B_ANDN] & ~and_gate_out) // R4
            | (m[`CMBF_B_ANDP] & and_gate_out); // R5
    end

    // =====================================
    // Filter clock source mux; reserved code stands still
    always @* begin
        case (filt_clk_src) // R8
            `CMBF_FS_T5: next_sclk = timer5_clk;
            `CMBF_FS_T4: next_sclk = timer4_clk;
            `CMBF_FS_T3: next_sclk = timer3_clk;
            `CMBF_FS_T2: next_sclk = timer2_clk;
            `CMBF_FS_SYNC: next_sclk = pwm_sync_out;
            `CMBF_FS_OSC: next_sclk = osc_clk;
            `CMBF_FS_PER: next_sclk = periph_clk;
            default: next_sclk = 1'b0;
        endcase
    end

    cmbf_filter u_filter (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick_src(next_sclk),
        .div(filt_clk_div), // R10
        .din(cmp_in),
        .dout(filt_level)
    );

    // =====================================
    // Output path: filter select then blanking, registered
    always @* begin
        blanked = filt_en ? filt_level : cmp_in; // R9
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmp_out <= 1'b0;
            blank_active <= 1'b0;
        end else begin
            blank_active <= or_out; // R13
            // Hold at the opposite level while the blanked level is present
            if (or_out && (blanked == ~blank_level_select)) begin
                cmp_out <= blank_level_select; // R1 R13
            end else begin
                cmp_out <= blanked;
            end
        end
    end

    // =====================================
    // AHB-Lite slave: zero wait states, write data in data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 12'h000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend <= addr_ok & hwrite & (hsize == `CMBF_HSIZE_WORD);
            wr_addr <= haddr;
        end
    end

    // Register writes
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask_gating_control <= 16'h0000;
            filter_control <= 16'h0000;
            mask_src_sel <= 16'h0000;
        end else if (wr_pend) begin
            if (wr_addr == `CMBF_OFS_MASK) begin
                mask_gating_control <= hwdata[15:0] & `CMBF_MASK_WMASK;
            end else if (wr_addr == `CMBF_OFS_FILT) begin
                filter_control <= hwdata[15:0] & `CMBF_FILT_WMASK; // R11
            end else if (wr_addr == `CMBF_OFS_SRC) begin
                mask_src_sel <= hwdata[15:0] & `CMBF_SRC_WMASK; // R12
            end
        end
    end

    // Read data registered from the address phase; unmapped reads zero
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (addr_ok && !hwrite) begin
            if (haddr == `CMBF_OFS_MASK) begin
                hrdata <= {16'h0000, mask_gating_control};
            end else if (haddr == `CMBF_OFS_FILT) begin
                hrdata <= {16'h0000, filter_control}; // R11
            end else if (haddr == `CMBF_OFS_SRC) begin
                hrdata <= {16'h0000, mask_src_sel};
            end else if (haddr == `CMBF_OFS_STAT) begin
                hrdata <= {29'h0, filt_level, blank_active, cmp_out};
            end else begin
                hrdata <= 32'h00000000;
            end
        end
    end
endmodule // cmbf_top

// >>> cmbf_defs.vh
// Constants for the comparator blanking and filter block
`ifndef CMBF_DEFS_VH
`define CMBF_DEFS_VH
// Register byte offsets
`define CMBF_OFS_MASK 12'h000
`define CMBF_OFS_FILT 12'h004
`define CMBF_OFS_SRC 12'h008
`define CMBF_OFS_STAT 12'h00C
// Mask gating field positions
`define CMBF_B_LVL 15
`define CMBF_B_OR_C 13
`define CMBF_B_OR_CN 12
`define CMBF_B_OR_B 11
`define CMBF_B_OR_BN 10
`define CMBF_B_OR_A 9
`define CMBF_B_OR_AN 8
`define CMBF_B_ANDN 7
`define CMBF_B_ANDP 6
`define CMBF_B_AND_C 5
`define CMBF_B_AND_CN 4
`define CMBF_B_AND_B 3
`define CMBF_B_AND_BN 2
`define CMBF_B_AND_A 1
`define CMBF_B_AND_AN 0
`define CMBF_MASK_WMASK 16'hBFFF
// Filter control fields
`define CMBF_FSRC_HI 6
`define CMBF_FSRC_LO 4
`define CMBF_B_FEN 3
`define CMBF_FDIV_HI 2
`define CMBF_FDIV_LO 0
`define CMBF_FILT_WMASK 16'h007F
`define CMBF_SRC_WMASK 16'h0FFF
// Mask source select fields
`define CMBF_SA_HI 3
`define CMBF_SA_LO 0
`define CMBF_SB_HI 7
`define CMBF_SB_LO 4
`define CMBF_SC_HI 11
`define CMBF_SC_LO 8
// Clock source codes
`define CMBF_FS_PER 3'h0
`define CMBF_FS_OSC 3'h1
`define CMBF_FS_SYNC 3'h2
`define CMBF_FS_RSV 3'h3
`define CMBF_FS_T2 3'h4
`define CMBF_FS_T3 3'h5
`define CMBF_FS_T4 3'h6
`define CMBF_FS_T5 3'h7
// Mask source codes
`define CMBF_MS_PTG0 4'hC
`define CMBF_MS_PTG1 4'hD
`define CMBF_MS_FLT0 4'hE
`define CMBF_MS_FLT1 4'hF
`define CMBF_MS_PWM_LAST 4'h5
// Filter stability count
`define CMBF_STABLE_CNT 2'h3
// AHB encodings
`define CMBF_HTRANS_NONSEQ 2'h2
`define CMBF_HSIZE_WORD 3'h2
`endif

// >>> cmbf_src_sel.v
// One mask source selector
`timescale 1ns/1ps
module cmbf_src_sel (
    input wire [3:0] sel, // Source code
    input wire [5:0] pwm, // PWM outputs
    input wire [1:0] trig, // Trigger generator outputs
    input wire [1:0] fault, // Fault inputs
    output reg out // Selected mask input
);
`include "cmbf_defs.vh"
    // =====================================
    // Source decode, reserved codes give zero
    always @* begin
        if (sel <= `CMBF_MS_PWM_LAST) begin
            out = pwm[sel[2:0]]; // R12
        end else if (sel == `CMBF_MS_PTG0) begin
            out = trig[0];
        end else if (sel == `CMBF_MS_PTG1) begin
            out = trig[1];
        end else if (sel == `CMBF_MS_FLT0) begin
            out = fault[0];
        end else if (sel == `CMBF_MS_FLT1) begin
            out = fault[1];
        end else begin
            out = 1'b0;
        end
    end
endmodule // cmbf_src_sel

// >>> cmbf_filter.v
// Digital filter: three stable samples on divided clock ticks
`timescale 1ns/1ps
module cmbf_filter (
    input wire hclk, // System clock
    input wire hresetn, // Async reset, active low
    input wire tick_src, // Selected sample clock level
    input wire [2:0] div, // Power of two divider code
    input wire din, // Raw comparator level
    output reg dout // Filtered level
);
`include "cmbf_defs.vh"
    reg tick_d;
    reg [6:0] pre;
    reg [1:0] cnt;
    reg last;
    wire rise;
    wire [7:0] ratio_m1;
    assign rise = tick_src & ~tick_d;
    assign ratio_m1 = (8'h01 << div) - 8'h01; // R10
    // =====================================
    // Edge detect, divide and vote
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_d <= 1'b0;
            pre <= 7'h00;
            cnt <= 2'h0;
            last <= 1'b0;
            dout <= 1'b0;
        end else begin
            tick_d <= tick_src;
            if (rise) begin
                if ({1'b0, pre} >= ratio_m1) begin
                    pre <= 7'h00;
                    // Sample on the divided edge
                    if (din != last) begin
                        last <= din;
                        cnt <= 2'h1;
                    end else if (cnt != `CMBF_STABLE_CNT) begin
                        cnt <= cnt + 2'h1;
                        if (cnt + 2'h1 == `CMBF_STABLE_CNT) begin
                            dout <= last; // R14
                        end
                    end
                end else begin
                    pre <= pre + 7'h01;
                end
            end
        end
    end
endmodule // cmbf_filter

// >>> cmbf_checker.sv
// Port checker for the comparator blanking and filter block
`timescale 1ns/1ps
module cmbf_checker (
    input wire hclk, // Clock
    input wire hresetn, // Reset, low
    input wire hsel, // Select
    input wire [11:0] haddr, // Address
    input wire [1:0] htrans, // Transfer
    input wire hwrite, // Write
    input wire [2:0] hsize, // Size
    input wire [31:0] hwdata, // Write data
    input wire hready, // Ready in
    input wire [31:0] hrdata, // Read data
    input wire hreadyout, // Ready out
    input wire hresp, // Response
    input wire cmp_in, // Raw level
    input wire cmp_out, // Result
    input wire blank_active // Blank
);
    // ======
    // Shadow registers, kept because the block hides them
    reg [15:0] msk;
    reg [6:0] flt;
    reg [11:0] wa;
    reg wv, rv;
    reg [2:0] qt;
    reg [1:0] up;
    wire take = hsel && hready && htrans == 2'h2;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {msk, flt, wa, wv, rv, qt, up} <= '0;
        end else begin
            wv <= take && hwrite && hsize == 3'h2;
            rv <= take && !hwrite;
            wa <= haddr;
            msk <= (wv && wa == 12'h000) ? hwdata[15:0] & 16'hBFFF : msk;
            flt <= (wv && wa == 12'h004) ? hwdata[6:0] : flt;
            up <= up + {1'b0, up != 2'h3};
            qt <= flt[6:3] != 4'h7 ? 3'h0 : qt + {2'h0, qt != 3'h7};
        end
    end
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    ready_high_a: assert property (hreadyout) else $error("ready dropped");
    resp_okay_a: assert property (!hresp) else $error("error response");
    upper_zero_a: assert property (rv |-> hrdata[31:16] == 16'h0000) else $error("upper bits set");
    filt_unimpl_a: assert property (rv && wa == 12'h004 |-> hrdata[15:7] == 9'h000)
        else $error("filter high bits set");
    no_terms_a: assert property (up == 2'h3 && $past(msk[13:6]) == 8'h00 |-> !blank_active)
        else $error("blank without terms");
    pass_thru_a: assert property (up == 2'h3 && !blank_active && !$past(blank_active) && !$past(flt[3])
        |-> cmp_out == $past(cmp_in)) else $error("bypass mismatch");
    blank_hold_a: assert property (up == 2'h3 && blank_active && $past(blank_active)
        && msk[15] == $past(msk[15]) && !$past(flt[3]) |-> cmp_out == msk[15]) else $error("blank not held");
    rsv_src_a: assert property (qt == 3'h7 && !blank_active && !$past(blank_active) && !$past(blank_active, 2)
        |-> $stable(cmp_out)) else $error("reserved source ticked");
    blank_seen_c: cover property (blank_active && cmp_out != cmp_in);
    rsv_seen_c: cover property (qt == 3'h7);
    filt_seen_c: cover property (flt[3] && $changed(cmp_out));
endmodule // cmbf_checker

// >>> cmbf_src_model.sv
// Sample clock sources standing outside the block
`timescale 1ns/1ps
module cmbf_src_model (
    input wire hclk, // Clock
    input wire hresetn, // Reset, low
    output wire [6:0] clks // Timer 5..2, sync, osc, periph
);
    // ======
    // One divider; distinct rates so a wrong pick shows, except osc and periph, which share cnt[0]
    reg [5:0] cnt;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= 6'h00;
        end else begin
            cnt <= cnt + 6'h01;
        end
    end
    assign clks = {cnt[4:1], cnt[5], cnt[0], cnt[0]};
endmodule // cmbf_src_model

// >>> comparator_blanking_and_filter_tb.sv
// Bench for the blanking and filter block over AHB-Lite
`timescale 1ns/1ps
module comparator_blanking_and_filter_tb;
    reg hclk, hresetn, hsel, hwrite, cmp_in, v;
    reg rd_pend = 1'b0;
    reg [11:0] haddr;
    reg [1:0] htrans, trig_out, fault_in;
    reg [2:0] hsize, fd;
    reg [31:0] hwdata, d;
    reg [5:0] pwm_out;
    reg [15:0] m;
    reg [3:0] sa, sb, sc;
    reg [31:0] eq[$], em[$];
    wire [31:0] hrdata;
    wire hreadyout, hresp, cmp_out, blank_active;
    wire [6:0] ck;
    integer bad_count, checks_done, seed, i, n, t;
    cmbf_src_model SRC (.hclk(hclk), .hresetn(hresetn), .clks(ck));
    cmbf_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .cmp_in(cmp_in), .pwm_out(pwm_out), .trig_out(trig_out), .fault_in(fault_in), .timer5_clk(ck[6]),
        .timer4_clk(ck[5]), .timer3_clk(ck[4]), .timer2_clk(ck[3]), .pwm_sync_out(ck[2]), .osc_clk(ck[1]),
        .periph_clk(ck[0]), .cmp_out(cmp_out), .blank_active(blank_active));
    // ======
    // Helpers: source pick, sample period, expected status
    function [3:0] pick(input integer r);
        pick = r < 6 ? r : r + 6;
    endfunction
    function integer per(input integer c);
        per = c < 2 ? 2 : c == 2 ? 64 : 2 << (c - 3);
    endfunction
    function lvl(input [3:0] c);
        lvl = c <= 4'h5 ? pwm_out[c] : c >= 4'hE ? fault_in[c - 4'hE] : trig_out[c - 4'hC];
    endfunction
    function [1:0] exp_st(input [15:0] k, input a, input b, input c);
        reg g, o;
        begin
            g = |k[5:0] & (a | !k[1]) & (!a | !k[0]) & (b | !k[3]) & (!b | !k[2]) & (c | !k[5]) & (!c | !k[4]);
            o = k[9] & a | k[8] & !a | k[11] & b | k[10] & !b | k[13] & c | k[12] & !c | k[6] & g | k[7] & !g;
            exp_st = {o, o ? k[15] : cmp_in};
        end
    endfunction
    // Bounded wait for ready; a hang ends the run
    task wait_rdy;
        begin
            n = 0;
            @(posedge hclk);
            while (hreadyout !== 1'b1 && n < 64) begin
                n = n + 1;
                @(posedge hclk);
            end
            if (n >= 64) begin
                bad_count = bad_count + 1;
                stop_test;
            end
        end
    endtask
    // Single word transfer; reads note their expectation
    task xfer(input w, input [11:0] a, input [31:0] dv, input [31:0] mk);
        begin
            hsel <= 1'b1;
            hwrite <= w;
            haddr <= a;
            htrans <= 2'h2;
            hsize <= 3'h2;
            if (!w) begin
                eq.push_back(dv);
                em.push_back(mk);
            end
            wait_rdy;
            htrans <= 2'h0;
            hwdata <= dv;
            wait_rdy;
        end
    endtask
    task chk_rd(input [31:0] e, input [31:0] mk);
        begin
            checks_done = checks_done + 1;
            if ((hrdata & mk) !== (e & mk)) begin
                bad_count = bad_count + 1;
                $display("[ERR] %0t read %h expected %h", $time, hrdata & mk, e & mk);
            end
        end
    endtask
    task stop_test;
        begin
            // A read noted but never answered is a miss
            if (eq.size() != 0) begin
                bad_count = bad_count + 1;
            end
            if (bad_count == 0 && checks_done > 0) begin
                $display("All checks passed");
            end else begin
                $display("Checks failed");
            end
            $finish;
        end
    endtask
    // Monitor pairs each read data phase with the oldest note
    always @(posedge hclk) begin
        if (rd_pend) begin
            chk_rd(eq.pop_front(), em.pop_front());
        end
        rd_pend <= hsel && hreadyout && htrans == 2'h2 && !hwrite;
    end
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    initial begin
        {hresetn, hsel, hwrite, cmp_in, haddr, htrans, hsize, hwdata, pwm_out, trig_out, fault_in} = 0;
        bad_count = 0;
        checks_done = 0;
        seed = 43117;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // Reset values, write masks, unmapped place
        for (i = 0; i < 4; i = i + 1) begin
            t = i == 3 ? 16 : 4 * i;
            d = $random(seed);
            xfer(0, t[11:0], 32'h0, 32'hFFFFFFFF);
            xfer(1, t[11:0], d, 32'h0);
            xfer(0, t[11:0], d & (i == 0 ? 32'hBFFF : i == 1 ? 32'h7F : i == 2 ? 32'hFFF : 0), 32'hFFFFFFFF);
        end
        // Blanking network with random terms and sources, filter off
        xfer(1, 12'h004, 32'h0, 32'h0);
        for (i = 0; i < 48; i = i + 1) begin
            d = $random(seed);
            m = d[31:16];
            sa = pick({$random(seed)} % 10);
            sb = pick({$random(seed)} % 10);
            sc = pick({$random(seed)} % 10);
            {pwm_out, trig_out, fault_in} <= d[9:0];
            cmp_in <= d[10];
            xfer(1, 12'h008, {20'h0, sc, sb, sa}, 32'h0);
            xfer(1, 12'h000, {16'h0, m}, 32'h0);
            repeat (3) @(posedge hclk);
            xfer(0, 12'h00C, {30'h0, exp_st(m, lvl(sa), lvl(sb), lvl(sc))}, 32'h3);
        end
        // Filter per source code and divider
        xfer(1, 12'h000, 32'h0, 32'h0);
        for (i = 0; i < 8; i = i + 1) begin
            d = $random(seed);
            fd = d[2:0];
            // Slow sources at deep division would blow the cycle budget
            if ((per(i) << fd) > 512) begin
                fd = fd - 3'h4;
            end
            t = per(i) << fd;
            xfer(1, 12'h004, {25'h0, i[2:0], 1'b1, fd}, 32'h0);
            repeat (4 * t + 8) @(posedge hclk);
            v = cmp_in;
            cmp_in <= !v;
            xfer(0, 12'h00C, {29'h0, v, 1'b0, v}, 32'h7);
            repeat (3 * t + 8) @(posedge hclk);
            v = i == 3 ? v : !v;
            xfer(0, 12'h00C, {29'h0, v, 1'b0, v}, 32'h7);
        end
        @(posedge hclk);
        stop_test;
    end
endmodule // comparator_blanking_and_filter_tb
bind cmbf_top cmbf_checker chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .cmp_in(cmp_in), .cmp_out(cmp_out), .blank_active(blank_active));
